// ==== logic/fsp_op_timer.sv ====
`timescale 1ns/1ns
module fsp_op_timer #(
	parameter int CYCLES = fsp_pkg::OP_MIN_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic por_n_i,
	input wire logic start_i,
	input wire fsp_pkg::fsp_op_t kind_i,
	input wire logic [7:0] arg_i,
	output logic busy_o,
	output logic done_o,
	output fsp_pkg::fsp_op_t kind_o,
	output logic [7:0] arg_o
);
	import fsp_pkg::*;

	fsp_timer_t s_q;
	fsp_timer_t s_d;

	// ----------------------------------------
	// Oscillator-timed operation, survives system reset
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			FSP_T_IDLE: begin
				if (start_i) begin
					s_d.st = FSP_T_RUN;
					s_d.kind = kind_i;
					s_d.arg = arg_i;
					s_d.cnt = OP_CNT_W'(CYCLES - 1); // R22
				end
			end
			FSP_T_RUN: begin
				if (s_q.cnt == '0) begin
					s_d.st = FSP_T_IDLE;
					// Kind stays so the done cycle still tells which operation ended
					s_d.done = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - 1'b1; // R22
				end
			end
			default: begin
				s_d.st = FSP_T_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge por_n_i) begin
		if (!por_n_i) begin
			s_q <= '{st: FSP_T_IDLE, kind: FSP_OP_NONE, arg: '0, cnt: '0, done: 1'b0};
		end else begin
			s_q <= s_d; // R21
		end
	end

	assign busy_o = (s_q.st == FSP_T_RUN);
	assign done_o = s_q.done;
	assign kind_o = s_q.kind;
	assign arg_o = s_q.arg;

endmodule

// ==== logic/fsp_page_buf.sv ====
`timescale 1ns/1ns
module fsp_page_buf #(
	parameter int AW = fsp_pkg::WORD_BITS,
	parameter int DW = 16
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	input wire logic wr_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [DW-1:0] wr_data_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [DW-1:0] rd_data_o
);
	import fsp_pkg::*;

	localparam int WORDS = 1 << AW;

	logic [DW-1:0] mem_q [WORDS];
	logic [WORDS-1:0] valid_q;

	// ----------------------------------------
	// Valid bits: cleared word reads as erased
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_q <= '0; // R2
		end else if (clr_i) begin
			valid_q <= '0; // R2
		end else if (wr_i) begin
			valid_q[wr_addr_i] <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (wr_i && !clr_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= DW'(ERASED_WORD);
		end else begin
			rd_data_o <= valid_q[rd_addr_i] ? mem_q[rd_addr_i] : DW'(ERASED_WORD);
		end
	end

endmodule

// ==== logic/fsp_pkg.sv ====
package fsp_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTL_IEN = 7;
	localparam int CTL_SBUSY = 6;
	localparam int CTL_SPE = 0;
	localparam int CMD_W = 5;
	localparam logic [CMD_W-1:0] CMD_NONE = 5'h00;
	localparam logic [CMD_W-1:0] CMD_LOAD = 5'h01;
	localparam logic [CMD_W-1:0] CMD_ERASE = 5'h03;
	localparam logic [CMD_W-1:0] CMD_WRITE = 5'h05;
	localparam logic [CMD_W-1:0] CMD_LOCK = 5'h09;
	localparam logic [CMD_W-1:0] CMD_REEN = 5'h11;

	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int ST_OP_BUSY = 0;
	localparam int ST_HALT = 1;
	localparam int ST_LOADED = 2;

	// ----------------------------------------
	// Instruction windows
	// ----------------------------------------
	localparam int WIN_W = 3;
	localparam logic [WIN_W-1:0] SPM_WINDOW = 3'h4;
	localparam logic [WIN_W-1:0] LPM_WINDOW = 3'h3;
	localparam logic [WIN_W-1:0] LPM_MIN_WIN = SPM_WINDOW - LPM_WINDOW + 3'h1;

	// ----------------------------------------
	// Pointer layout
	// ----------------------------------------
	localparam int Z_W = 16;
	localparam int WORD_LSB = 1;
	localparam int WORD_BITS = 5;
	localparam int PAGE_LSB = 6;
	localparam int PAGE_BITS = 7;
	localparam int RWW_PAGES = 96;
	localparam logic [Z_W-1:0] Z_FUSE_LOW = 16'h0000;
	localparam logic [Z_W-1:0] Z_LOCK = 16'h0001;
	localparam logic [Z_W-1:0] Z_FUSE_EXT = 16'h0002;
	localparam logic [Z_W-1:0] Z_FUSE_HIGH = 16'h0003;
	localparam logic [7:0] EXT_FUSE_MASK = 8'h0F;
	localparam logic [7:0] LOCK_BITS_MASK = 8'h3C;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	// ----------------------------------------
	// Operation timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int OP_MIN_NS = 3_700_000;
	localparam int OP_MAX_NS = 4_500_000;
	localparam int OP_MIN_CYCLES = (OP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OP_MAX_CYCLES = OP_MAX_NS / CLK_PERIOD_NS;
	localparam int OP_CNT_W = 16;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		FSP_OP_NONE = 3'b000,
		FSP_OP_ERASE = 3'b001,
		FSP_OP_WRITE = 3'b010,
		FSP_OP_LOCK = 3'b100
	} fsp_op_t;

	typedef enum logic [1:0] {
		FSP_T_IDLE = 2'b01,
		FSP_T_RUN = 2'b10
	} fsp_tstate_t;

	typedef struct packed {
		fsp_tstate_t st;
		fsp_op_t kind;
		logic [7:0] arg;
		logic [OP_CNT_W-1:0] cnt;
		logic done;
	} fsp_timer_t;

	typedef struct packed {
		logic ien;
		logic [CMD_W-1:0] cmd;
		logic [WIN_W-1:0] win;
		logic sbusy;
		logic loaded;
		logic resp;
		logic [31:0] rdata;
		logic [7:0] lpm_data;
		logic lpm_take;
	} fsp_state_t;

endpackage

// ==== logic/fsp_top.sv ====
`timescale 1ns/1ns
//Behaviour
//R1: Load code then store within four cycles writes data word into buffer slot.
//R2: Buffer clears after page write, on re-enable write, and on reset.
//R3: Software writes each buffer slot at most once between clears.
//R4: EEPROM write during buffer loading discards all loaded words.
//R5: Write code then store programs buffer into selected page.
//R6: Software sets only page field in pointer for page write.
//R7: Low-section write keeps boot section readable; boot-section write halts CPU.
//R8: Ready interrupt stays asserted while enabled and self-program enable clear.
//R9: Erase or write blocks low section; busy flag stays set meanwhile.
//R10: Software writes re-enable after programming before reading low section.
//R11: Lock code then store updates boot lock bits from data byte.
//R12: Zero bits 5..2 of lock byte program lock bits; pointer ignored.
//R13: Software should use pointer 0x0001 and ones in bits 7,6,1,0.
//R14: Lock programming blocks neither section.
//R15: Pending EEPROM write refuses commands and fuse or lock reads.
//R16: Software should check EEPROM pending flag before writing control.
//R17: Lock code then load within three cycles at 0x0001 returns lock bits.
//R18: Enable bits clear on read done or missed load or store window.
//R19: Load at 0x0000, 0x0003, 0x0002 returns low, high, extended fuse.
//R20: Programmed fuse and lock bits read zero, unprogrammed read one.
//R21: Flash write already running completes despite system reset.
//R22: Erase, write and lock operations last 3.7 ms to 4.5 ms.
//R23: Control writes with invalid low five bits have no effect; the code still writes IEN from bit 7.
//R24: Self-program enable stays set until erase or write completes.
//R25: Erase code then store erases the selected page.
module fsp_top #(
	parameter int OP_CYCLES = fsp_pkg::OP_MIN_CYCLES,
	parameter int RWW_PAGES = fsp_pkg::RWW_PAGES
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	input wire logic [fsp_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic spm_i,
	input wire logic lpm_i,
	input wire logic [fsp_pkg::Z_W-1:0] z_ptr_i,
	input wire logic [15:0] r_data_i,
	output logic lpm_take_o,
	output logic [7:0] lpm_data_o,
	input wire logic eeprom_write_pending_i,
	input wire logic [7:0] low_fuse_prog_i,
	input wire logic [7:0] high_fuse_prog_i,
	input wire logic [7:0] extended_fuse_prog_i,
	input wire logic [7:0] lock_prog_i,
	output logic spm_ready_irq_o,
	output logic rww_read_block_o,
	output logic cpu_halt_o,
	output logic flash_erase_o,
	output logic flash_write_o,
	output logic lock_write_o,
	output logic [fsp_pkg::PAGE_BITS-1:0] flash_page_o,
	output logic [7:0] lock_set_mask_o,
	input wire logic [fsp_pkg::WORD_BITS-1:0] buf_rd_addr_i,
	output logic [15:0] buf_rd_data_o
);
	import fsp_pkg::*;

	fsp_state_t s_q;
	fsp_state_t s_d;

	logic op_busy;
	logic op_done;
	fsp_op_t op_kind;
	logic [7:0] op_arg;
	logic op_start;
	fsp_op_t start_kind;
	logic [7:0] start_arg;
	logic buf_clr;
	logic buf_wr;
	logic spe_vis;
	logic no_read_during_write_section_target;
	logic rww_op;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic cmd_valid(input logic [CMD_W-1:0] c);
		cmd_valid = (c == CMD_LOAD) || (c == CMD_ERASE) || (c == CMD_WRITE) ||
			(c == CMD_LOCK) || (c == CMD_REEN);
	endfunction

	assign spe_vis = (s_q.cmd[CTL_SPE] | op_busy); // R24
	assign no_read_during_write_section_target = (32'(op_arg[PAGE_BITS-1:0]) >= RWW_PAGES);
	// Erase or write running on the low section, also across a system reset
	assign rww_op = op_busy & (op_kind != FSP_OP_LOCK) & ~no_read_during_write_section_target;

	// ----------------------------------------
	// Sequencer and register slave
	// ----------------------------------------
	always_comb begin
		logic req;
		logic wr_take;
		logic rd_take;
		logic spm_ok;
		logic lpm_ok;
		logic [7:0] wbyte;
		req = avs_read_i | avs_write_i;
		wr_take = avs_write_i & s_q.resp;
		rd_take = avs_read_i & ~s_q.resp;
		wbyte = avs_writedata_i[7:0];
		spm_ok = spm_i & (s_q.win != '0) & ~eeprom_write_pending_i; // R15
		lpm_ok = lpm_i & (s_q.win >= LPM_MIN_WIN);
		s_d = s_q;
		op_start = 1'b0;
		start_kind = FSP_OP_NONE;
		start_arg = '0;
		buf_clr = 1'b0;
		buf_wr = 1'b0;
		s_d.lpm_take = 1'b0;
		s_d.resp = req & ~s_q.resp;

		// Window countdown, missed store or load drops the command
		if (s_q.win != '0) begin
			s_d.win = s_q.win - 1'b1;
			if (s_q.win == 3'h1) begin
				s_d.cmd = CMD_NONE; // R18
			end
		end

		// Store instruction inside the window
		if (spm_ok) begin
			s_d.win = '0;
			case (s_q.cmd)
				CMD_LOAD: begin
					buf_wr = 1'b1; // R1
					s_d.loaded = 1'b1;
					s_d.sbusy = 1'b0;
					s_d.cmd = CMD_NONE;
				end
				CMD_REEN: begin
					s_d.sbusy = 1'b0;
					s_d.cmd = CMD_NONE;
				end
				CMD_ERASE: begin
					op_start = 1'b1; // R25
					s_d.cmd = s_q.cmd;
					start_kind = FSP_OP_ERASE;
					start_arg = 8'(z_ptr_i[PAGE_LSB +: PAGE_BITS]);
				end
				CMD_WRITE: begin
					op_start = 1'b1; // R5
					s_d.cmd = s_q.cmd;
					start_kind = FSP_OP_WRITE;
					start_arg = 8'(z_ptr_i[PAGE_LSB +: PAGE_BITS]);
				end
				CMD_LOCK: begin
					op_start = 1'b1; // R11
					s_d.cmd = s_q.cmd;
					start_kind = FSP_OP_LOCK;
					start_arg = ~r_data_i[7:0] & LOCK_BITS_MASK; // R12
				end
				default: begin
					s_d.cmd = CMD_NONE;
				end
			endcase
		end

		// Low-section erase and write block the low section, lock does not
		if (op_start && start_kind != FSP_OP_LOCK &&
			32'(start_arg[PAGE_BITS-1:0]) < RWW_PAGES) begin
			s_d.sbusy = 1'b1; // R9 R14
		end

		// Flag held set while a low-section operation runs, also after a system reset
		if (rww_op) begin
			s_d.sbusy = 1'b1; // R9 R21
		end

		// Load instruction reads fuse or lock bytes
		if (lpm_ok && s_q.cmd == CMD_LOCK && !spm_ok) begin
			s_d.cmd = CMD_NONE; // R18
			s_d.win = '0;
			if (!eeprom_write_pending_i) begin // R15
				s_d.lpm_take = 1'b1;
				case (z_ptr_i)
					Z_FUSE_LOW: s_d.lpm_data = ~low_fuse_prog_i; // R19 R20
					Z_LOCK: s_d.lpm_data = ~lock_prog_i; // R17 R20
					Z_FUSE_EXT: s_d.lpm_data = ~(extended_fuse_prog_i & EXT_FUSE_MASK); // R19
					Z_FUSE_HIGH: s_d.lpm_data = ~high_fuse_prog_i; // R19
					default: s_d.lpm_take = 1'b0;
				endcase
			end
		end

		// Operation end
		if (op_done) begin
			s_d.cmd = CMD_NONE; // R24
			if (op_kind == FSP_OP_WRITE) begin
				buf_clr = 1'b1; // R2
			end
		end

		// Control register write
		if (wr_take && avs_byteenable_i[0] && avs_address_i == CTRL_OFS) begin
			s_d.ien = wbyte[CTL_IEN];
			if (cmd_valid(wbyte[CMD_W-1:0]) && !op_busy && !eeprom_write_pending_i) begin // R23 R15
				s_d.cmd = wbyte[CMD_W-1:0];
				s_d.win = SPM_WINDOW;
				if (wbyte[CMD_W-1:0] == CMD_REEN) begin
					buf_clr = 1'b1; // R2
				end
			end
		end

		// EEPROM write in the middle of loading
		if (eeprom_write_pending_i && s_q.loaded) begin
			buf_clr = 1'b1; // R4
		end
		if (buf_clr) begin
			s_d.loaded = 1'b0;
			buf_wr = 1'b0;
		end

		// Read data
		if (rd_take) begin
			case (avs_address_i)
				CTRL_OFS: begin
					s_d.rdata = '0;
					s_d.rdata[CTL_IEN] = s_q.ien;
					s_d.rdata[CTL_SBUSY] = s_q.sbusy | rww_op; // R9
					s_d.rdata[CMD_W-1:1] = s_q.cmd[CMD_W-1:1];
					s_d.rdata[CTL_SPE] = spe_vis; // R24
				end
				STAT_OFS: begin
					s_d.rdata = '0;
					s_d.rdata[ST_LOADED] = s_q.loaded;
					s_d.rdata[ST_HALT] = cpu_halt_o;
					s_d.rdata[ST_OP_BUSY] = op_busy;
				end
				default: begin
					s_d.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '{ien: CTRL_RESET[CTL_IEN], cmd: CMD_NONE, win: '0, sbusy: CTRL_RESET[CTL_SBUSY],
				loaded: 1'b0, resp: 1'b0, rdata: '0, lpm_data: '0, lpm_take: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	fsp_op_timer #(
		.CYCLES(OP_CYCLES)
	) u_timer (
		.clk_sys_i(clk_sys_i),
		.por_n_i(por_n_i),
		.start_i(op_start),
		.kind_i(start_kind),
		.arg_i(start_arg),
		.busy_o(op_busy),
		.done_o(op_done),
		.kind_o(op_kind),
		.arg_o(op_arg)
	);

	fsp_page_buf #(
		.AW(WORD_BITS),
		.DW(16)
	) u_buf (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.clr_i(buf_clr),
		.wr_i(buf_wr),
		.wr_addr_i(z_ptr_i[WORD_LSB +: WORD_BITS]),
		.wr_data_i(r_data_i),
		.rd_addr_i(buf_rd_addr_i),
		.rd_data_o(buf_rd_data_o)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s_q.resp;
	assign avs_readdata_o = s_q.rdata;
	assign lpm_take_o = s_q.lpm_take;
	assign lpm_data_o = s_q.lpm_data;
	assign spm_ready_irq_o = s_q.ien & ~spe_vis; // R8
	assign rww_read_block_o = s_q.sbusy | rww_op; // R9
	assign cpu_halt_o = op_busy & (op_kind != FSP_OP_LOCK) & no_read_during_write_section_target; // R7 R14
	assign flash_erase_o = op_busy & (op_kind == FSP_OP_ERASE);
	assign flash_write_o = op_busy & (op_kind == FSP_OP_WRITE);
	assign lock_write_o = op_busy & (op_kind == FSP_OP_LOCK);
	assign flash_page_o = op_arg[PAGE_BITS-1:0];
	assign lock_set_mask_o = op_arg;

endmodule

// ==== test/fsp_assertions.sv ====
`timescale 1ns/1ns
module fsp_assertions
	import fsp_pkg::*;
#(
	parameter int OP_CYCLES = fsp_pkg::OP_MIN_CYCLES,
	parameter int RWW_PAGES = fsp_pkg::RWW_PAGES
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	input wire logic lpm_i,
	input wire logic eeprom_write_pending_i,
	input wire logic lpm_take_o,
	input wire logic spm_ready_irq_o,
	input wire logic rww_read_block_o,
	input wire logic cpu_halt_o,
	input wire logic flash_erase_o,
	input wire logic flash_write_o,
	input wire logic lock_write_o,
	input wire logic [fsp_pkg::PAGE_BITS-1:0] flash_page_o,
	input wire logic [7:0] lock_set_mask_o
);
	// ----------------------------------------
	// Operation length counter
	// ----------------------------------------
	logic op;
	logic op_q;
	logic [15:0] cnt_q;
	assign op = flash_erase_o | flash_write_o | lock_write_o;
	// Power-on reset only, so a running operation is still measured across system reset
	always_ff @(posedge clk_sys_i or negedge por_n_i) begin
		if (!por_n_i) begin
			op_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else begin
			op_q <= op;
			cnt_q <= op ? cnt_q + 16'h0001 : 16'h0000;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_op_length: assert property (op_q && !op |-> cnt_q == 16'(OP_CYCLES))
		else $error("operation length differs from the set cycle count");
	a_op_bound: assert property (op |-> cnt_q < 16'(OP_CYCLES))
		else $error("operation runs past the set cycle count");
	a_irq_quiet: assert property (op |-> !spm_ready_irq_o)
		else $error("ready interrupt during an operation");
	a_rww_block: assert property ((flash_write_o || flash_erase_o) && op_q && flash_page_o < RWW_PAGES
		|-> rww_read_block_o)
		else $error("low section not blocked during erase or write");
	a_halt_no_read_during_write_section: assert property (cpu_halt_o == ((flash_write_o || flash_erase_o) && flash_page_o >= RWW_PAGES))
		else $error("halt does not match boot section operation");
	a_lock_free: assert property (lock_write_o && op_q |-> !cpu_halt_o && $stable(rww_read_block_o))
		else $error("lock programming blocks a section");
	a_lock_mask: assert property (lock_write_o |-> (lock_set_mask_o & 8'hC3) == 8'h00)
		else $error("lock mask outside bits five to two");
	a_load_answer: assert property (lpm_take_o |-> $past(lpm_i))
		else $error("load answer without a load one cycle before");
	a_ee_noread: assert property (lpm_take_o |-> !$past(eeprom_write_pending_i))
		else $error("fuse or lock read while eeprom write pending");

	c_write: cover property ($rose(flash_write_o));
	c_lock: cover property ($rose(lock_write_o));
	c_take: cover property (lpm_take_o);
	c_halt: cover property (cpu_halt_o);
endmodule

bind fsp_top fsp_assertions #(.OP_CYCLES(OP_CYCLES), .RWW_PAGES(RWW_PAGES)) chk_u (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .lpm_i(lpm_i),
	.eeprom_write_pending_i(eeprom_write_pending_i), .lpm_take_o(lpm_take_o), .spm_ready_irq_o(spm_ready_irq_o),
	.rww_read_block_o(rww_read_block_o), .cpu_halt_o(cpu_halt_o), .flash_erase_o(flash_erase_o),
	.flash_write_o(flash_write_o), .lock_write_o(lock_write_o), .flash_page_o(flash_page_o),
	.lock_set_mask_o(lock_set_mask_o)
);

// ==== test/fsp_core_model.sv ====
`timescale 1ns/1ns
module fsp_core_model (
	input wire logic clk_sys_i,
	output logic spm_o,
	output logic lpm_o,
	output logic [15:0] z_ptr_o,
	output logic [15:0] r_data_o
);
	initial begin
		spm_o = 1'b0;
		lpm_o = 1'b0;
		z_ptr_o = 16'h5A5A;
		r_data_o = 16'hA5A5;
	end

	// ----------------------------------------
	// One store or load instruction, dly cycles late
	// ----------------------------------------
	task automatic exec(input logic ld, input logic [15:0] z, input logic [15:0] r, input int dly);
		repeat (dly) @(posedge clk_sys_i);
		spm_o <= !ld;
		lpm_o <= ld;
		z_ptr_o <= z;
		r_data_o <= r;
		@(posedge clk_sys_i);
		spm_o <= 1'b0;
		lpm_o <= 1'b0;
		// Operands no longer valid after the instruction
		z_ptr_o <= ~z;
		r_data_o <= ~r;
	endtask
endmodule

// ==== test/fsp_tb_top.sv ====
`timescale 1ns/1ns
module fsp_tb_top;
	import fsp_pkg::*;
	localparam int OPC = 20;
	localparam logic [7:0] BAD [3] = '{8'h07, 8'h13, 8'h0B};
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic por_n_i = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic ee = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [4:0] badr = 5'h00;
	logic [7:0] fl = 8'h12, fh = 8'h34, fe = 8'h05, lk = 8'h28;
	logic [31:0] rdat, v;
	logic wreq, spm, lpm, take, irq, blk, halt, fer, fwr, lwr;
	logic [15:0] z, r, bdat;
	logic [7:0] ldat, mask;
	logic [6:0] page;
	int n_fail = 0;
	int n_tests = 0;

	always #50 clk_sys_i = ~clk_sys_i;

	fsp_top #(.OP_CYCLES(OPC), .RWW_PAGES(96)) dut_u (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .spm_i(spm), .lpm_i(lpm), .z_ptr_i(z), .r_data_i(r), .lpm_take_o(take),
		.lpm_data_o(ldat), .eeprom_write_pending_i(ee), .low_fuse_prog_i(fl), .high_fuse_prog_i(fh),
		.extended_fuse_prog_i(fe), .lock_prog_i(lk), .spm_ready_irq_o(irq), .rww_read_block_o(blk),
		.cpu_halt_o(halt), .flash_erase_o(fer), .flash_write_o(fwr), .lock_write_o(lwr), .flash_page_o(page),
		.lock_set_mask_o(mask), .buf_rd_addr_i(badr), .buf_rd_data_o(bdat)
	);
	fsp_core_model core_u (.clk_sys_i(clk_sys_i), .spm_o(spm), .lpm_o(lpm), .z_ptr_o(z), .r_data_o(r));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_lvl(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		do @(posedge clk_sys_i); while (wreq !== 1'b0);
		v = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic ctl(input logic [7:0] d);
		bus(1'b1, CTRL_OFS, {24'h0, d});
	endtask

	task automatic ctl_chk(input logic [7:0] e);
		bus(1'b0, CTRL_OFS, 32'h0);
		chk(v, {24'h0, e});
	endtask

	task automatic buf_chk(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk_sys_i);
		badr <= a;
		repeat (2) @(posedge clk_sys_i);
		chk({16'h0, bdat}, {16'h0, e});
	endtask

	task automatic wait_idle;
		do @(posedge clk_sys_i); while (fer || fwr || lwr);
		@(posedge clk_sys_i);
	endtask

	function automatic logic [7:0] fuse_exp(input int i);
		case (i)
			0: return ~fl;
			1: return ~lk;
			2: return ~fe | ~EXT_FUSE_MASK;
			default: return ~fh;
		endcase
	endfunction

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_fail++;
		complete_run();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		por_n_i <= 1'b1;
		ctl_chk(CTRL_RESET);
		bus(1'b1, 4'hC, 32'hFF);
		bus(1'b0, 4'hC, 32'h0);
		chk(v, 32'h0);
		ctl(8'h01);
		core_u.exec(1'b0, 16'h0006, 16'hBEEF, 0);
		buf_chk(5'h03, 16'hBEEF);
		buf_chk(5'h04, ERASED_WORD);
		@(posedge clk_sys_i);
		ee <= 1'b1;
		@(posedge clk_sys_i);
		ee <= 1'b0;
		buf_chk(5'h03, ERASED_WORD);
		ctl(8'h01);
		core_u.exec(1'b0, 16'h0002, 16'h1234, 1);
		ctl(8'h11);
		buf_chk(5'h01, ERASED_WORD);
		ctl(8'h01);
		core_u.exec(1'b0, 16'h0000, 16'hCAFE, 2);
		ctl(8'h85);
		core_u.exec(1'b0, 16'h00C0, 16'h0000, 3);
		repeat (2) @(posedge clk_sys_i);
		chk_lvl(fwr, 1'b1);
		chk(32'(page), 32'h3);
		chk_lvl(blk, 1'b1);
		chk_lvl(halt, 1'b0);
		chk_lvl(irq, 1'b0);
		bus(1'b0, CTRL_OFS, 32'h0);
		chk_lvl(v[CTL_SPE], 1'b1);
		bus(1'b0, STAT_OFS, 32'h0);
		chk(v, (32'h1 << ST_LOADED) | (32'h1 << ST_OP_BUSY));
		wait_idle();
		ctl_chk(8'hC0);
		chk_lvl(irq, 1'b1);
		buf_chk(5'h00, ERASED_WORD);
		ctl(8'h11);
		core_u.exec(1'b0, 16'h0000, 16'h0000, 0);
		repeat (2) @(posedge clk_sys_i);
		chk_lvl(blk, 1'b0);
		foreach (BAD[i]) begin
			ctl(BAD[i]);
			core_u.exec(1'b0, 16'h00C0, 16'h0000, 0);
			ctl_chk(8'h00);
			chk_lvl(fer || fwr || lwr, 1'b0);
		end
		ctl(8'h05);
		core_u.exec(1'b0, 16'h00C0, 16'h0000, 4);
		ctl_chk(8'h00);
		chk_lvl(fwr, 1'b0);
		ctl(8'h03);
		core_u.exec(1'b0, 16'h1900, 16'h0000, 1);
		repeat (2) @(posedge clk_sys_i);
		chk_lvl(fer, 1'b1);
		chk_lvl(halt, 1'b1);
		chk(32'(page), 32'h64);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		chk_lvl(fer, 1'b1);
		wait_idle();
		chk_lvl(halt, 1'b0);
		ctl(8'h09);
		core_u.exec(1'b0, 16'h0001, 16'h00E7, 2);
		repeat (2) @(posedge clk_sys_i);
		chk_lvl(lwr, 1'b1);
		chk({24'h0, mask}, {24'h0, ~8'hE7 & LOCK_BITS_MASK});
		chk_lvl(blk || halt, 1'b0);
		wait_idle();
		for (int i = 0; i < 4; i++) begin
			ctl(8'h09);
			core_u.exec(1'b1, 16'(i), 16'h0000, 2);
			@(posedge clk_sys_i);
			chk_lvl(take, 1'b1);
			chk({24'h0, ldat}, {24'h0, fuse_exp(i)});
			ctl_chk(8'h00);
		end
		@(posedge clk_sys_i);
		ctl(8'h09);
		ee <= 1'b1;
		core_u.exec(1'b1, Z_LOCK, 16'h0000, 1);
		@(posedge clk_sys_i);
		chk_lvl(take, 1'b0);
		ctl(8'h05);
		core_u.exec(1'b0, 16'h00C0, 16'h0000, 0);
		repeat (2) @(posedge clk_sys_i);
		chk_lvl(fwr, 1'b0);
		ctl_chk(8'h00);
		ee <= 1'b0;
		complete_run();
	end
endmodule
